// ==== inc/ddc_pkg.sv ====
// Shared constants and types for the command decoder
package ddc_pkg;

    // ==================================================================
    // Decoded command codes
    typedef enum logic [4:0] {
        CMD_NONE  = 5'h00,
        CMD_MRS   = 5'h01,
        CMD_REF   = 5'h02,
        CMD_SRE   = 5'h03,
        CMD_SRX   = 5'h04,
        CMD_PRE   = 5'h05,
        CMD_PREA  = 5'h06,
        CMD_ACT   = 5'h07,
        CMD_WR    = 5'h08,
        CMD_WRA   = 5'h09,
        CMD_RD    = 5'h0A,
        CMD_RDA   = 5'h0B,
        CMD_NOP   = 5'h0C,
        CMD_PDE   = 5'h0D,
        CMD_PDX   = 5'h0E,
        CMD_ZQCL  = 5'h0F,
        CMD_ZQCS  = 5'h10
    } ddc_cmd_t;

    // ==================================================================
    // Power states
    typedef enum logic [1:0] {
        ST_ACTIVE = 2'b00,
        ST_PDOWN  = 2'b01,
        ST_SREF   = 2'b10
    } ddc_state_t;

    // ==================================================================
    // Command pin groups {RAS_n, CAS_n, WE_n} with ACT_n high
    localparam logic [2:0] RCW_MRS  = 3'h0;
    localparam logic [2:0] RCW_REF  = 3'h1;
    localparam logic [2:0] RCW_PRE  = 3'h2;
    localparam logic [2:0] RCW_RFU  = 3'h3;
    localparam logic [2:0] RCW_WR   = 3'h4;
    localparam logic [2:0] RCW_RD   = 3'h5;
    localparam logic [2:0] RCW_ZQ   = 3'h6;
    localparam logic [2:0] RCW_NOP  = 3'h7;

    // ==================================================================
    // Address field positions
    localparam int ADDR_W      = 14;
    localparam int COL_W       = 10;
    localparam int AP_BIT      = 10;
    localparam int BC_BIT      = 12;
    localparam int OP_W        = 18;
    localparam int MR_SEL_W    = 3;
    localparam int BG_MAX_W    = 2;
    localparam int BA_W        = 2;
    localparam int ROW_MAX_W   = 18;

    // ==================================================================
    // Burst mode select and burst occupancy in clocks
    localparam logic [1:0] BLM_FIXED_BL8 = 2'h0;
    localparam logic [1:0] BLM_OTF       = 2'h1;
    localparam logic [1:0] BLM_FIXED_BC4 = 2'h2;
    localparam logic [3:0] BURST_CYC_BL8 = 4'h4;
    localparam logic [3:0] BURST_CYC_BC4 = 4'h2;

    // Reset and default values
    localparam logic       CKE_PREV_RST  = 1'b0;
    localparam int         SREF_TICK_DEF = 1024;

endpackage

// ==== rtl/ddc_burst.sv ====
// Burst occupancy tracker: a started burst always runs to its end
`timescale 1ns/100ps

module ddc_burst (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic start,
    input  wire logic start_wr,
    input  wire logic start_chop,
    output logic      active_reg,
    output logic      write_reg,
    output logic      chop_reg
);

    // ==================================================================
    // Counter and one-deep pending slot
    logic [3:0] cnt_reg;
    logic       pend_reg;
    logic       pend_wr_reg;
    logic       pend_chop_reg;
    logic       last;
    logic       load;
    logic       load_wr;
    logic       load_chop;

    assign last      = active_reg && (cnt_reg == 4'h1);
    // A new burst never cuts the running one; it waits for the last beat
    assign load      = (start && (!active_reg || last)) || (last && pend_reg);
    assign load_wr   = (last && pend_reg) ? pend_wr_reg : start_wr;
    assign load_chop = (last && pend_reg) ? pend_chop_reg : start_chop;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg    <= 4'h0;
            active_reg <= 1'b0;
            write_reg  <= 1'b0;
            chop_reg   <= 1'b0;
        end else if (load) begin
            cnt_reg    <= load_chop ? ddc_pkg::BURST_CYC_BC4
                                    : ddc_pkg::BURST_CYC_BL8;
            active_reg <= 1'b1;
            write_reg  <= load_wr;
            chop_reg   <= load_chop;
        end else if (active_reg) begin
            cnt_reg    <= cnt_reg - 4'h1;
            active_reg <= !last;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            pend_reg      <= 1'b0;
            pend_wr_reg   <= 1'b0;
            pend_chop_reg <= 1'b0;
        // A start on the last beat queues behind a waiting burst
        end else if (start && active_reg &&
                     (!last || pend_reg)) begin
            pend_reg      <= 1'b1;
            pend_wr_reg   <= start_wr;
            pend_chop_reg <= start_chop;
        end else if (last) begin
            pend_reg      <= 1'b0;
        end
    end

endmodule

// ==== rtl/ddc_decoder.sv ====
// Command decoder with power state tracking and burst occupancy
// Notes on behaviour
// - Command comes from CS, ACT, three muxed pins, A10 and CKE at rising edge.
// - ACT high: muxed pins act as row strobe, column strobe, write enable.
// - ACT low with CS low: bank activate, muxed pins are row bits 16..14.
// - Mode set: CS and the muxed pins low, ACT high; BG0 and bank bits pick register, address opcode.
// - A17 is reserved during mode set; presence depends on density.
// - Row high, column low: write if write-enable low, else read; column A9..0.
// - A started read or write burst is never cut; burst length set by mode.
// - Valid inputs are driven; don't-care inputs are ignored by the device.
// - Termination input never affects decode; off during self refresh.
// - No internal refresh happens while in power-down.
// - Bank group and bank together select the target bank.
// - Upper bank group, bank, row and column bits depend on density; here only BG_W, ROW_W and HAS_A17 vary, bank and column widths are fixed.
// - Deselect accepts no command; running operations carry on.
`timescale 1ns/100ps

module ddc_decoder #(
    parameter int BG_W        = 2,
    parameter int ROW_W       = 18,
    parameter bit HAS_A17     = 1'b1,
    parameter int SREF_TICK   = ddc_pkg::SREF_TICK_DEF
) (
    input  wire logic                          CLK_SYS,
    input  wire logic                          ARST_N,
    input  wire logic                          CKE,
    input  wire logic                          CS_N,
    input  wire logic                          ACT_N,
    input  wire logic                          RAS_N_A16,
    input  wire logic                          CAS_N_A15,
    input  wire logic                          WE_N_A14,
    input  wire logic [BG_W-1:0]               BG,
    input  wire logic [ddc_pkg::BA_W-1:0]      BA,
    input  wire logic                          ADDR17,
    input  wire logic [ddc_pkg::ADDR_W-1:0]    ADDR,
    input  wire logic                          ODT,
    input  wire logic [1:0]                    BURST_MODE,
    output logic                               CMD_VALID,
    output ddc_pkg::ddc_cmd_t                  CMD_CODE,
    output logic                               CMD_ILLEGAL,
    output logic [BG_W-1:0]                    CMD_BG,
    output logic [ddc_pkg::BA_W-1:0]           CMD_BA,
    output logic [ROW_W-1:0]                   CMD_ROW,
    output logic [ddc_pkg::COL_W-1:0]          CMD_COL,
    output logic                               CMD_CHOP,
    output logic [ddc_pkg::MR_SEL_W-1:0]       MR_SEL,
    output logic [ddc_pkg::OP_W-1:0]           MR_OPCODE,
    output ddc_pkg::ddc_state_t                POWER_STATE,
    output logic                               ODT_EN,
    output logic                               SREF_REFRESH,
    output logic                               BURST_ACTIVE,
    output logic                               BURST_WRITE,
    output logic                               BURST_CHOP
);

    // ==================================================================
    // Elaboration checks
    if (BG_W < 1 || BG_W > ddc_pkg::BG_MAX_W) begin
        $error("BG_W must be 1 or 2");
    end
    if (ROW_W < ddc_pkg::ADDR_W + 1 || ROW_W > ddc_pkg::ROW_MAX_W) begin
        $error("ROW_W out of range");
    end
    if (SREF_TICK < 2) begin
        $error("SREF_TICK must be at least 2");
    end

    localparam int TICK_W = $clog2(SREF_TICK);

    // ==================================================================
    // Sampled pin groups
    logic                     cke_prev_reg;
    ddc_pkg::ddc_state_t      state_reg;
    ddc_pkg::ddc_state_t      state_next;
    logic [2:0]               rcw;
    logic                     selected;
    logic                     cke_hold;
    logic                     cke_fall;
    logic                     cke_rise;
    logic [ddc_pkg::ROW_MAX_W-1:0] row_full;
    logic                     a17_eff;

    assign rcw      = {RAS_N_A16, CAS_N_A15, WE_N_A14};
    assign selected = !CS_N;
    assign cke_hold = cke_prev_reg && CKE;
    assign cke_fall = cke_prev_reg && !CKE;
    assign cke_rise = !cke_prev_reg && CKE;
    // Muxed pins become row bits while ACT is low
    assign a17_eff  = HAS_A17 ? ADDR17 : 1'b0;
    assign row_full = {a17_eff, RAS_N_A16, CAS_N_A15, WE_N_A14, ADDR};

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            cke_prev_reg <= ddc_pkg::CKE_PREV_RST;
        end else begin
            cke_prev_reg <= CKE;
        end
    end

    // ==================================================================
    // Command decode
    ddc_pkg::ddc_cmd_t cmd_next;
    logic              illegal_next;
    logic              burst_start;
    logic              burst_wr;
    logic              chop_next;

    always_comb begin
        cmd_next     = ddc_pkg::CMD_NONE;
        illegal_next = 1'b0;
        state_next   = state_reg;
        case (state_reg)
            ddc_pkg::ST_ACTIVE: begin
                if (cke_hold && selected) begin
                    if (!ACT_N) begin
                        cmd_next = ddc_pkg::CMD_ACT;
                    end else begin
                        case (rcw)
                            ddc_pkg::RCW_MRS: cmd_next = ddc_pkg::CMD_MRS;
                            ddc_pkg::RCW_REF: cmd_next = ddc_pkg::CMD_REF;
                            ddc_pkg::RCW_PRE: begin
                                cmd_next = ADDR[ddc_pkg::AP_BIT]
                                         ? ddc_pkg::CMD_PREA
                                         : ddc_pkg::CMD_PRE;
                            end
                            ddc_pkg::RCW_WR: begin
                                cmd_next = ADDR[ddc_pkg::AP_BIT]
                                         ? ddc_pkg::CMD_WRA
                                         : ddc_pkg::CMD_WR;
                            end
                            ddc_pkg::RCW_RD: begin
                                cmd_next = ADDR[ddc_pkg::AP_BIT]
                                         ? ddc_pkg::CMD_RDA
                                         : ddc_pkg::CMD_RD;
                            end
                            ddc_pkg::RCW_ZQ: begin
                                cmd_next = ADDR[ddc_pkg::AP_BIT]
                                         ? ddc_pkg::CMD_ZQCL
                                         : ddc_pkg::CMD_ZQCS;
                            end
                            ddc_pkg::RCW_NOP: cmd_next = ddc_pkg::CMD_NOP;
                            // Reserved code is flagged, never acted on
                            default: illegal_next = 1'b1;
                        endcase
                    end
                end else if (cke_fall) begin
                    if (CS_N) begin
                        cmd_next   = ddc_pkg::CMD_PDE;
                        state_next = ddc_pkg::ST_PDOWN;
                    end else if (ACT_N && rcw == ddc_pkg::RCW_REF) begin
                        cmd_next   = ddc_pkg::CMD_SRE;
                        state_next = ddc_pkg::ST_SREF;
                    end else begin
                        illegal_next = 1'b1;
                    end
                end
            end
            ddc_pkg::ST_PDOWN: begin
                // Pins other than CKE are don't-care until the exit edge
                if (cke_rise && CS_N) begin
                    cmd_next   = ddc_pkg::CMD_PDX;
                    state_next = ddc_pkg::ST_ACTIVE;
                end else if (cke_rise) begin
                    illegal_next = 1'b1;
                end
            end
            ddc_pkg::ST_SREF: begin
                // Exit is caught on the clock, a choice the link allows
                if (cke_rise && (CS_N ||
                    (ACT_N && rcw == ddc_pkg::RCW_NOP))) begin
                    cmd_next   = ddc_pkg::CMD_SRX;
                    state_next = ddc_pkg::ST_ACTIVE;
                end else if (cke_rise) begin
                    illegal_next = 1'b1;
                end
            end
            default: begin
                state_next = ddc_pkg::ST_ACTIVE;
            end
        endcase
    end

    assign burst_wr    = (cmd_next == ddc_pkg::CMD_WR) ||
                         (cmd_next == ddc_pkg::CMD_WRA);
    assign burst_start = burst_wr || (cmd_next == ddc_pkg::CMD_RD) ||
                         (cmd_next == ddc_pkg::CMD_RDA);

    // Burst length comes from the mode setting, per command only on the fly
    always_comb begin
        case (BURST_MODE)
            ddc_pkg::BLM_FIXED_BL8: chop_next = 1'b0;
            ddc_pkg::BLM_OTF:       chop_next = !ADDR[ddc_pkg::BC_BIT];
            ddc_pkg::BLM_FIXED_BC4: chop_next = 1'b1;
            default:                chop_next = 1'b0;
        endcase
    end

    // ==================================================================
    // Power state and command strobe
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            state_reg   <= ddc_pkg::ST_ACTIVE;
            POWER_STATE <= ddc_pkg::ST_ACTIVE;
        end else begin
            state_reg   <= state_next;
            POWER_STATE <= state_next;
        end
    end

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            CMD_VALID   <= 1'b0;
            CMD_CODE    <= ddc_pkg::CMD_NONE;
            CMD_ILLEGAL <= 1'b0;
        end else begin
            CMD_VALID   <= (cmd_next != ddc_pkg::CMD_NONE);
            CMD_CODE    <= cmd_next;
            CMD_ILLEGAL <= illegal_next;
        end
    end

    // ==================================================================
    // Address capture, only fields valid for the command are loaded
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            CMD_BG   <= '0;
            CMD_BA   <= '0;
            CMD_ROW  <= '0;
            CMD_COL  <= '0;
            CMD_CHOP <= 1'b0;
        end else begin
            case (cmd_next)
                ddc_pkg::CMD_ACT: begin
                    CMD_BG  <= BG;
                    CMD_BA  <= BA;
                    CMD_ROW <= row_full[ROW_W-1:0];
                end
                ddc_pkg::CMD_WR, ddc_pkg::CMD_WRA,
                ddc_pkg::CMD_RD, ddc_pkg::CMD_RDA: begin
                    CMD_BG   <= BG;
                    CMD_BA   <= BA;
                    CMD_COL  <= ADDR[ddc_pkg::COL_W-1:0];
                    CMD_CHOP <= chop_next;
                end
                ddc_pkg::CMD_PRE: begin
                    CMD_BG <= BG;
                    CMD_BA <= BA;
                end
                default: begin
                    // Don't-care pins never reach the outputs
                    CMD_CHOP <= CMD_CHOP;
                end
            endcase
        end
    end

    // ==================================================================
    // Mode register target and opcode
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            MR_SEL    <= '0;
            MR_OPCODE <= '0;
        end else if (cmd_next == ddc_pkg::CMD_MRS) begin
            MR_SEL    <= {BG[0], BA};
            // A17 passes through as reserved; muxed bits read low here
            MR_OPCODE <= {a17_eff, 3'h0, ADDR};
        end
    end

    // ==================================================================
    // Termination gate: looked at only here, never by the decode
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            ODT_EN <= 1'b0;
        end else begin
            ODT_EN <= ODT && (state_next != ddc_pkg::ST_SREF);
        end
    end

    // ==================================================================
    // Internal refresh ticks, only while in self refresh
    logic [TICK_W-1:0] tick_reg;

    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            tick_reg     <= '0;
            SREF_REFRESH <= 1'b0;
        end else if (state_next == ddc_pkg::ST_SREF) begin
            SREF_REFRESH <= (tick_reg == TICK_W'(SREF_TICK - 1));
            tick_reg     <= (tick_reg == TICK_W'(SREF_TICK - 1))
                          ? '0 : tick_reg + 1'b1;
        end else begin
            // Power-down and active both clear the internal timer
            tick_reg     <= '0;
            SREF_REFRESH <= 1'b0;
        end
    end

    // ==================================================================
    // Burst occupancy
    ddc_burst u_burst (
        .clk        (CLK_SYS),
        .arst_n     (ARST_N),
        .start      (burst_start),
        .start_wr   (burst_wr),
        .start_chop (chop_next),
        .active_reg (BURST_ACTIVE),
        .write_reg  (BURST_WRITE),
        .chop_reg   (BURST_CHOP)
    );

endmodule

// ==== dv/ddc_decoder_sva.sv ====
// Port assertions for the command decoder
`timescale 1ns/100ps
module ddc_decoder_sva #(
    parameter int BG_W  = 2,
    parameter int ROW_W = 18
) (
    input wire logic                CLK_SYS,
    input wire logic                ARST_N,
    input wire logic                CKE,
    input wire logic                CS_N,
    input wire logic                ACT_N,
    input wire logic                RAS_N_A16,
    input wire logic                CAS_N_A15,
    input wire logic                WE_N_A14,
    input wire logic [BG_W-1:0]     BG,
    input wire logic [1:0]          BA,
    input wire logic [13:0]         ADDR,
    input wire logic                CMD_VALID,
    input wire ddc_pkg::ddc_cmd_t   CMD_CODE,
    input wire logic                CMD_ILLEGAL,
    input wire logic [ROW_W-1:0]    CMD_ROW,
    input wire logic [9:0]          CMD_COL,
    input wire logic [2:0]          MR_SEL,
    input wire logic [17:0]         MR_OPCODE,
    input wire ddc_pkg::ddc_state_t POWER_STATE,
    input wire logic                ODT_EN,
    input wire logic                BURST_ACTIVE,
    input wire logic                BURST_CHOP
);
    // ==================================================================
    // Helpers; cke_q mirrors the decoder's previous CKE, reset low
    logic       cke_q;
    logic       sel;
    logic       selc;
    logic [2:0] rcw;
    always_ff @(posedge CLK_SYS or negedge ARST_N) begin
        if (!ARST_N) begin
            cke_q <= ddc_pkg::CKE_PREV_RST;
        end else begin
            cke_q <= CKE;
        end
    end
    assign rcw  = {RAS_N_A16, CAS_N_A15, WE_N_A14};
    assign sel  = cke_q && CKE && !CS_N && POWER_STATE == ddc_pkg::ST_ACTIVE;
    assign selc = sel && ACT_N;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!ARST_N);
    // ==================================================================
    // Checks
    a_act_row: assert property (sel && !ACT_N |=>
        CMD_ROW[16:0] == $past({rcw, ADDR}))
        else $error("activate row not loaded");
    a_mrs_sel: assert property (selc && rcw == ddc_pkg::RCW_MRS |=>
        MR_SEL == $past({BG[0], BA}) && MR_OPCODE[13:0] == $past(ADDR))
        else $error("mode register target wrong");
    a_rw_col: assert property (selc && rcw[2:1] == 2'h2 |=>
        CMD_COL == $past(ADDR[9:0]) && $past(WE_N_A14) ==
        (CMD_CODE inside {ddc_pkg::CMD_RD, ddc_pkg::CMD_RDA}))
        else $error("read or write decode wrong");
    a_des_none: assert property (cke_q && CKE && CS_N |=>
        !CMD_VALID) else $error("deselect gave a command");
    a_rfu_flag: assert property (selc && rcw == ddc_pkg::RCW_RFU |=>
        CMD_ILLEGAL) else $error("reserved code not flagged");
    a_sre_entry: assert property (cke_q && !CKE && !CS_N && ACT_N &&
        rcw == ddc_pkg::RCW_REF && POWER_STATE == ddc_pkg::ST_ACTIVE |=>
        POWER_STATE == ddc_pkg::ST_SREF) else $error("no self refresh");
    a_odt_sref: assert property (POWER_STATE == ddc_pkg::ST_SREF |->
        !ODT_EN) else $error("termination on in self refresh");
    a_burst_len: assert property ($rose(BURST_ACTIVE) && !BURST_CHOP |->
        BURST_ACTIVE[*4]) else $error("burst cut short");
endmodule

bind ddc_decoder ddc_decoder_sva #(.BG_W(BG_W), .ROW_W(ROW_W))
    ddc_decoder_sva_inst (.*);

// ==== dv/ddc_ctrl_model.sv ====
// Memory controller model driving the command bus
`timescale 1ns/100ps
module ddc_ctrl_model (
    input  wire logic   clk,
    output logic        cke,
    output logic        cs_n,
    output logic        act_n,
    output logic [2:0]  pins,
    output logic [1:0]  bg,
    output logic [1:0]  ba,
    output logic        a17,
    output logic [13:0] addr
);
    initial begin
        cke = 1'b1;
        cs_n = 1'b1;
        {act_n, pins, bg, ba, a17, addr} = '0;
    end
    // ==================================================================
    // One command for one edge, then deselect; idle lines are inverted
    // so a decoder that peeks at don't-cares cannot pass by luck
    task automatic issue(input logic k, input logic c, input logic a,
                         input logic [2:0] p, input logic [13:0] ad);
        @(posedge clk);
        cke <= k;
        cs_n <= c;
        {act_n, pins, bg, ba, a17, addr} <= {a, p, 4'h9, 1'b0, ad};
        @(posedge clk);
        cs_n <= 1'b1;
        {act_n, pins, bg, ba, a17, addr} <=
            ~{act_n, pins, bg, ba, a17, addr};
    endtask
endmodule

// ==== dv/ddc_decoder_tb_top.sv ====
// Self-checking bench for the command decoder
`timescale 1ns/100ps
module ddc_decoder_tb_top;
    // ==================================================================
    // Wiring
    logic                clk_sys = 1'b0;
    logic                arst_n  = 1'b0;
    logic                odt     = 1'b0;
    logic                cke, cs_n, act_n, a17, c_vld, c_ill;
    logic                odt_en, b_act, c_chop, b_wr, b_chop;
    logic [1:0]          b_mode  = 2'h0;
    // Short self refresh tick so the pulse is reached quickly
    localparam int       tick_len = 8;
    logic [2:0]          pins, mr_sel;
    logic [1:0]          bg, ba, c_bg, c_ba;
    logic [13:0]         addr;
    logic [17:0]         c_row, mr_op;
    logic [9:0]          c_col;
    ddc_pkg::ddc_cmd_t   code;
    ddc_pkg::ddc_state_t pst;
    int                  n_mismatch = 0;
    int                  cmp_count  = 0;
    always #2 clk_sys = ~clk_sys;
    ddc_decoder #(.SREF_TICK(tick_len)) ddc_decoder_inst (
        .CLK_SYS(clk_sys), .ARST_N(arst_n), .CKE(cke), .CS_N(cs_n),
        .ACT_N(act_n), .RAS_N_A16(pins[2]), .CAS_N_A15(pins[1]),
        .WE_N_A14(pins[0]), .BG(bg), .BA(ba), .ADDR17(a17), .ADDR(addr),
        .ODT(odt), .BURST_MODE(b_mode), .CMD_VALID(c_vld), .CMD_CODE(code),
        .CMD_ILLEGAL(c_ill), .CMD_BG(c_bg), .CMD_BA(c_ba), .CMD_ROW(c_row),
        .CMD_COL(c_col), .CMD_CHOP(c_chop), .MR_SEL(mr_sel),
        .MR_OPCODE(mr_op), .POWER_STATE(pst), .ODT_EN(odt_en),
        .SREF_REFRESH(), .BURST_ACTIVE(b_act), .BURST_WRITE(b_wr),
        .BURST_CHOP(b_chop));
    ddc_ctrl_model ddc_ctrl_model_inst (.clk(clk_sys), .cke(cke),
        .cs_n(cs_n), .act_n(act_n), .pins(pins), .bg(bg), .ba(ba),
        .a17(a17), .addr(addr));
    // ==================================================================
    // Helpers
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: %s", $time, what);
        end
    endtask
    task automatic tick();
        @(posedge clk_sys);
        #1;
    endtask
    // Returns with the command's outputs settled
    task automatic cmd(input logic k, input logic c, input logic a,
                       input logic [2:0] p, input logic [13:0] ad);
        ddc_ctrl_model_inst.issue(k, c, a, p, ad);
        #1;
    endtask
    // ==================================================================
    // Scenarios
    task automatic t_table();
        ddc_pkg::ddc_cmd_t ex [10] = '{ddc_pkg::CMD_MRS, ddc_pkg::CMD_REF,
            ddc_pkg::CMD_PRE, ddc_pkg::CMD_PREA, ddc_pkg::CMD_WR,
            ddc_pkg::CMD_WRA, ddc_pkg::CMD_RD, ddc_pkg::CMD_RDA,
            ddc_pkg::CMD_ZQCS, ddc_pkg::CMD_ZQCL};
        logic [3:0] en [10] = '{4'h0, 4'h1, 4'h2, 4'hA, 4'h4, 4'hC,
                               4'h5, 4'hD, 4'h6, 4'hE};
        for (int i = 0; i < 10; i++) begin
            cmd(1'b1, 1'b0, 1'b1, en[i][2:0], {3'h4, en[i][3], 10'h2A5});
            chk(c_vld, 1'b1, "no command");
            chk(code, ex[i], "code");
            if (i == 0) begin
                chk({mr_sel, mr_op}, 21'h0422A5, "mode set");
            end
            if (i >= 4 && i < 8) begin
                chk({c_bg, c_ba, c_col}, 14'h26A5, "column");
            end
        end
        cmd(1'b1, 1'b0, 1'b0, 3'h5, 14'h3C3C);
        chk(code, ddc_pkg::CMD_ACT, "activate");
        chk(c_row, 18'h17C3C, "row");
        cmd(1'b1, 1'b0, 1'b1, ddc_pkg::RCW_RFU, 14'h0000);
        chk(c_ill, 1'b1, "reserved code");
        cmd(1'b1, 1'b1, 1'b0, 3'h5, 14'h0000);
        chk(c_vld, 1'b0, "deselect");
        $display("t_table done");
    endtask
    task automatic t_burst();
        int n = 0;
        for (int i = 0; i < 40 && b_act !== 1'b0; i++) tick();
        cmd(1'b1, 1'b0, 1'b1, ddc_pkg::RCW_RD, 14'h0000);
        chk(b_act, 1'b1, "burst start");
        cmd(1'b1, 1'b0, 1'b1, ddc_pkg::RCW_WR, 14'h0000);
        while (b_act === 1'b1 && n < 20) begin
            n++;
            tick();
        end
        chk(n, 6, "burst length");
        @(posedge clk_sys);
        b_mode <= ddc_pkg::BLM_OTF;
        cmd(1'b1, 1'b0, 1'b1, ddc_pkg::RCW_WR, 14'h0000);
        chk({c_chop, b_chop, b_wr}, 3'h7, "chopped write");
        n = 0;
        while (b_act === 1'b1 && n < 20) begin
            n++;
            tick();
        end
        chk(n, ddc_pkg::BURST_CYC_BC4, "chop length");
        @(posedge clk_sys);
        b_mode <= ddc_pkg::BLM_FIXED_BC4;
        cmd(1'b1, 1'b0, 1'b1, ddc_pkg::RCW_RD, 14'h1000);
        chk({c_chop, b_chop, b_wr}, 3'h6, "fixed chop read");
        $display("t_burst done");
    endtask
    task automatic t_power();
        int n = 0;
        cmd(1'b0, 1'b1, 1'b1, 3'h7, 14'h0000);
        chk(pst, ddc_pkg::ST_PDOWN, "power-down entry");
        // Longer than one tick period, so a running timer would show
        for (int i = 0; i < 10; i++) begin
            tick();
            chk(ddc_decoder_inst.SREF_REFRESH, 1'b0, "pd refresh");
        end
        cmd(1'b0, 1'b0, 1'b1, 3'h5, 14'h0000);
        chk(c_vld, 1'b0, "command in power-down");
        cmd(1'b1, 1'b1, 1'b1, 3'h7, 14'h0000);
        chk(code, ddc_pkg::CMD_PDX, "power-down exit");
        @(posedge clk_sys);
        odt <= 1'b1;
        tick();
        chk(odt_en, 1'b1, "termination");
        cmd(1'b0, 1'b0, 1'b1, ddc_pkg::RCW_REF, 14'h0000);
        chk(code, ddc_pkg::CMD_SRE, "self refresh entry");
        chk(odt_en, 1'b0, "termination in self refresh");
        while (ddc_decoder_inst.SREF_REFRESH !== 1'b1 && n < 20) begin
            n++;
            tick();
        end
        // The entry edge already counts as the first tick
        chk(n, tick_len - 1, "refresh tick");
        cmd(1'b1, 1'b1, 1'b1, 3'h7, 14'h0000);
        chk({code, pst}, {ddc_pkg::CMD_SRX, ddc_pkg::ST_ACTIVE}, "exit");
        $display("t_power done");
    endtask
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (10) @(posedge clk_sys);
        #1;
        chk({code, pst}, {ddc_pkg::CMD_NONE, ddc_pkg::ST_ACTIVE}, "rst");
        @(posedge clk_sys);
        arst_n <= 1'b1;
        tick();
        t_table();
        t_burst();
        t_power();
        give_verdict();
    end
    // Whole run is under two hundred cycles; this is ample
    initial begin
        #20000;
        n_mismatch++;
        give_verdict();
    end
endmodule
